// File: rtl/tfp_pin_control.sv
// Pin control, serial slave and register file of the thermal fan controller
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "tfp_consts.svh"

// Behaviour
// - Low fan-off output requests fan off
// - Released fan-off output allows fan to run
// - Polarity-selectable general input sets status bit 4
// - Floating general input reads zero, high reads one
// - Low auxiliary reset input resets the device
// - Power lost: fan output off, remote-off cleared
// - Serial message pulses remote reset output low
// - Board test enable high selects NAND test
// - Outside test mode, shared pin is fan output
// - Primary over-temp output low on setpoint violation
// - Fan full speed while over-temp asserted
// - Test mode routes NAND result to primary pin
// - Secondary over-temp output mirrors primary outside test mode
// - Serial message drives remote-off output high
// - Remote-off and its bit hold until power lost
// - Interrupt output drives only when config bit 1 set
// - Interrupt enable cleared after reset
// - Serial slave answers at address 0101110
// - First write byte loads pointer, second writes register
// - Mask register suppresses each interrupt source
module tfp_pin_control
    import tfp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pins
    input wire logic general_input,
    input wire logic aux_reset_n,
    input wire logic mainPowerN,
    input wire logic board_test_enable,
    input wire logic smbScl,
    input wire logic smbSdaIn,
    output logic smbSdaOut,
    output logic smbSdaOe,
    input wire logic overTempHit,
    output logic [7:0] fan_speed_analog,
    output logic fanSpeedOe,
    output logic fanOffOut,
    output logic fanOffOe,
    output logic over_temp_primary_n,
    output logic overTempPrimaryOe,
    output logic over_temp_secondary_n,
    output logic overTempSecondaryOe,
    output logic remoteResetOut,
    output logic remoteResetOe,
    output logic remoteOff,
    output logic intOut,
    output logic intOe
);
    localparam int RRST_CYCLES = `TFP_RRST_CYCLES;
    localparam int TREE_W = 5;
    tfp_pins_t pinRaw;
    tfp_pins_t pinMeta_q;
    tfp_pins_t pinSync_q;
    tfp_pins_t pinPrev_q;
    logic devReset;
    logic testMode;
    logic powerLost;
    logic gpiActive;
    logic sclRise;
    logic sclFall;
    logic smbStart;
    logic smbStop;
    logic [7:0] config_q;
    logic [7:0] intStatus_q;
    logic [7:0] intMask_q;
    logic [7:0] fanDac_q;
    logic remoteOff_q;
    logic [4:0] rrstCount_q;
    logic [7:0] fanDrive_q;
    logic treeOut_q;
    logic [TREE_W-1:0] treeIn;
    logic [TREE_W-1:0] treeChain;
    tfp_wr_t ahbWr;
    tfp_wr_t smbWr;
    tfp_wr_t wr;
    logic ahbWrPend_q;
    logic [2:0] ahbIdx_q;
    logic ahbMapped_q;
    tfp_smb_state_t smbState_q;
    logic [3:0] bitCount_q;
    logic [7:0] shift_q;
    logic [7:0] smbPtr_q;
    logic firstByte_q;
    logic readMode_q;
    logic sdaLow_q;
    logic [7:0] stsSet, stsClr;
    logic [7:0] smbRdByte;

    assign pinRaw = {smbScl, smbSdaIn, board_test_enable, mainPowerN, aux_reset_n, general_input};

    // Two-stage synchroniser; third stage only for edge detection
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pinMeta_q <= `TFP_PIN_RESET;
            pinSync_q <= `TFP_PIN_RESET;
            pinPrev_q <= `TFP_PIN_RESET;
        end else begin
            pinMeta_q <= pinRaw;
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
        end
    end

    // Aux pin joins the reset; synchronisers stay on the plain reset
    assign devReset = reset | ~pinSync_q.auxResetN;
    assign testMode = pinSync_q.boardTestEnable;
    assign powerLost = ~pinSync_q.mainPowerN;
    // Undriven pin assumed pulled low externally, so it reads as zero
    assign gpiActive = pinSync_q.generalInput == config_q[`TFP_CFG_GPI_HIGH];
    assign sclRise = pinSync_q.scl & ~pinPrev_q.scl;
    assign sclFall = ~pinSync_q.scl & pinPrev_q.scl;
    assign smbStart = pinSync_q.scl & pinPrev_q.scl & ~pinSync_q.sda & pinPrev_q.sda;
    assign smbStop = pinSync_q.scl & pinPrev_q.scl & pinSync_q.sda & ~pinPrev_q.sda;

    // Register read mux shared by both ports
    function automatic logic [7:0] regRead(input logic [2:0] idx);
        logic [7:0] v;
        v = `TFP_BYTE_ZERO;
        case (idx)
            `TFP_IDX_CONFIG: v = config_q;
            `TFP_IDX_INT_STATUS: v = intStatus_q;
            `TFP_IDX_INT_MASK: v = intMask_q;
            `TFP_IDX_FAN_DAC: v = fanDac_q;
            `TFP_IDX_REMOTE: v[`TFP_REM_OFF] = remoteOff_q;
            `TFP_IDX_ALERT: begin
                v[`TFP_ALERT_OVER_TEMP] = overTempHit;
                v[`TFP_ALERT_GPI] = gpiActive;
                v[`TFP_ALERT_PWR_LOST] = powerLost;
                v[`TFP_ALERT_TEST] = testMode;
            end
            default: v = `TFP_BYTE_ZERO;
        endcase
        return v;
    endfunction : regRead

    // AHB-Lite: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase capture; read data registered for the data phase
    always_ff @(posedge sys_clk) begin
        if (devReset) begin
            ahbWrPend_q <= 1'b0;
            ahbIdx_q <= `TFP_IDX_CONFIG;
            ahbMapped_q <= 1'b0;
            hrdata <= '0;
        end else if (hready) begin
            ahbWrPend_q <= hsel & hwrite & htrans[1];
            ahbIdx_q <= haddr[4:2];
            ahbMapped_q <= (haddr[31:5] == '0) && (haddr[4:2] <= `TFP_IDX_ALERT);
            if (hsel & ~hwrite & htrans[1] & (haddr[31:5] == '0)) begin
                hrdata <= {24'h00_0000, regRead(haddr[4:2])};
            end else begin
                hrdata <= '0;
            end
        end
    end

    assign ahbWr = '{en: ahbWrPend_q & ahbMapped_q, idx: ahbIdx_q, data: hwdata[7:0]};
    // Bus port wins a same-cycle collision; serial write then lost
    assign wr = ahbWr.en ? ahbWr : smbWr;

    // Configuration: fan-off, interrupt enable, input polarity
    always_ff @(posedge sys_clk) begin
        if (devReset) begin
            config_q <= `TFP_BYTE_ZERO;
        end else if (wr.en && wr.idx == `TFP_IDX_CONFIG) begin
            config_q <= wr.data;
        end
    end

    // Mask and fan code registers
    always_ff @(posedge sys_clk) begin
        if (devReset) begin
            intMask_q <= `TFP_BYTE_ZERO;
            fanDac_q <= `TFP_BYTE_ZERO;
        end else if (wr.en) begin
            if (wr.idx == `TFP_IDX_INT_MASK) begin
                intMask_q <= wr.data;
            end
            if (wr.idx == `TFP_IDX_FAN_DAC) begin
                fanDac_q <= wr.data;
            end
        end
    end

    // Sticky status, write one to clear; a new event beats the clear
    assign stsClr = (wr.en && wr.idx == `TFP_IDX_INT_STATUS) ? wr.data : `TFP_BYTE_ZERO;
    assign stsSet = (8'(gpiActive) << `TFP_INT_GPI) | (8'(overTempHit) << `TFP_INT_OVER_TEMP);
    always_ff @(posedge sys_clk) begin
        if (devReset) begin
            intStatus_q <= `TFP_BYTE_ZERO;
        end else begin
            intStatus_q <= (intStatus_q & ~stsClr) | stsSet;
        end
    end

    // Remote-off latch; power loss wins over a same-cycle set
    always_ff @(posedge sys_clk) begin
        if (devReset || powerLost) begin
            remoteOff_q <= 1'b0;
        end else if (wr.en && wr.idx == `TFP_IDX_REMOTE && wr.data[`TFP_REM_OFF]) begin
            remoteOff_q <= 1'b1;
        end
    end

    // Remote reset pulse timer; a new trigger restarts it
    always_ff @(posedge sys_clk) begin
        if (devReset) begin
            rrstCount_q <= '0;
        end else if (wr.en && wr.idx == `TFP_IDX_REMOTE && wr.data[`TFP_REM_RESET]) begin
            rrstCount_q <= 5'(RRST_CYCLES);
        end else if (rrstCount_q != '0) begin
            rrstCount_q <= rrstCount_q - 5'd1;
        end
    end

    // Fan drive: off on power loss, full on over-temp, else code
    always_ff @(posedge sys_clk) begin
        if (devReset || powerLost) begin
            fanDrive_q <= `TFP_BYTE_ZERO;
        end else if (overTempHit) begin
            fanDrive_q <= `TFP_BYTE_FULL;
        end else begin
            fanDrive_q <= fanDac_q;
        end
    end

    // NAND tree over the digital inputs, one gate per stage
    assign treeIn = {pinSync_q.generalInput, pinSync_q.auxResetN, pinSync_q.mainPowerN,
                     pinSync_q.scl, pinSync_q.sda};
    assign treeChain[0] = treeIn[0];
    generate
        for (genvar i = 1; i < TREE_W; i++) begin : g_tree
            assign treeChain[i] = ~(treeChain[i-1] & treeIn[i]);
        end
    endgenerate
    always_ff @(posedge sys_clk) begin
        if (devReset) begin
            treeOut_q <= 1'b0;
        end else begin
            treeOut_q <= treeChain[TREE_W-1];
        end
    end

    // Pin drivers; open-drain pins enable only to pull low, except the primary pin in test mode
    assign fan_speed_analog = fanDrive_q;
    assign fanSpeedOe = ~testMode;
    assign fanOffOut = 1'b0;
    assign fanOffOe = config_q[`TFP_CFG_FAN_OFF];
    assign over_temp_primary_n = testMode ? treeOut_q : 1'b0;
    assign overTempPrimaryOe = testMode | overTempHit;
    assign over_temp_secondary_n = 1'b0;
    assign overTempSecondaryOe = overTempHit;
    assign remoteResetOut = 1'b0;
    assign remoteResetOe = rrstCount_q != '0;
    assign remoteOff = remoteOff_q;
    assign intOut = 1'b0;
    assign intOe = config_q[`TFP_CFG_INT_EN] & |(intStatus_q & ~intMask_q);
    assign smbSdaOut = 1'b0;
    assign smbSdaOe = sdaLow_q;

    // Serial write request toward the register file
    assign smbWr = '{en: smbState_q == SMB_WDATA && sclFall && bitCount_q == `TFP_BIT_LAST
                         && !firstByte_q && smbPtr_q[7:3] == '0,
                     idx: smbPtr_q[2:0], data: shift_q};
    // Byte a serial read returns; pointers past the map read zero
    always_comb smbRdByte = regRead(smbPtr_q[2:0]) & {8{smbPtr_q[7:3] == '0}};

    // Serial bus slave on sampled clock and data
    always_ff @(posedge sys_clk) begin
        if (devReset || smbStop) begin
            smbState_q <= SMB_IDLE;
            bitCount_q <= '0;
            shift_q <= '0;
            firstByte_q <= 1'b0;
            readMode_q <= 1'b0;
            sdaLow_q <= 1'b0;
        end else if (smbStart) begin
            smbState_q <= SMB_ADDR;
            bitCount_q <= '0;
            sdaLow_q <= 1'b0;
        end else begin
            case (smbState_q)
                SMB_ADDR, SMB_WDATA: begin
                    if (sclRise && bitCount_q != `TFP_BIT_LAST) begin
                        shift_q <= {shift_q[6:0], pinSync_q.sda};
                        bitCount_q <= bitCount_q + 4'd1;
                    end else if (sclFall && bitCount_q == `TFP_BIT_LAST) begin
                        if (smbState_q == SMB_WDATA) begin
                            sdaLow_q <= 1'b1;
                            firstByte_q <= 1'b0;
                            smbState_q <= SMB_WACK;
                        end else if (shift_q[7:1] == `TFP_SMB_ADDR) begin
                            sdaLow_q <= 1'b1;
                            readMode_q <= shift_q[0];
                            firstByte_q <= ~shift_q[0];
                            smbState_q <= SMB_ADDR_ACK;
                        end else begin
                            smbState_q <= SMB_IDLE;
                        end
                    end
                end
                SMB_ADDR_ACK, SMB_WACK: begin
                    if (sclFall) begin
                        bitCount_q <= '0;
                        if (readMode_q) begin
                            shift_q <= smbRdByte;
                            sdaLow_q <= ~smbRdByte[7];
                            smbState_q <= SMB_RDATA;
                        end else begin
                            sdaLow_q <= 1'b0;
                            smbState_q <= SMB_WDATA;
                        end
                    end
                end
                SMB_RDATA: begin
                    if (sclRise) begin
                        bitCount_q <= bitCount_q + 4'd1;
                    end else if (sclFall) begin
                        if (bitCount_q == `TFP_BIT_LAST) begin
                            sdaLow_q <= 1'b0; // Master acknowledges
                            smbState_q <= SMB_RACK;
                        end else begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            sdaLow_q <= ~shift_q[6];
                        end
                    end
                end
                SMB_RACK: begin
                    // Master NACK ends the read; ACK resends the same register
                    if (sclRise) begin
                        smbState_q <= pinSync_q.sda ? SMB_IDLE : SMB_ADDR_ACK;
                    end
                end
                default: smbState_q <= SMB_IDLE;
            endcase
        end
    end

    // Pointer load from the first byte of each write
    always_ff @(posedge sys_clk) begin
        if (devReset) begin
            smbPtr_q <= `TFP_BYTE_ZERO;
        end else if (smbState_q == SMB_WDATA && sclFall && bitCount_q == `TFP_BIT_LAST
                     && firstByte_q) begin
            smbPtr_q <= shift_q;
        end
    end
endmodule : tfp_pin_control

// File: rtl/tfp_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef TFP_CONSTS_SVH
`define TFP_CONSTS_SVH
`define TFP_IDX_W 3
`define TFP_IDX_CONFIG 3'h0
`define TFP_IDX_INT_STATUS 3'h1
`define TFP_IDX_INT_MASK 3'h2
`define TFP_IDX_FAN_DAC 3'h3
`define TFP_IDX_REMOTE 3'h4
`define TFP_IDX_ALERT 3'h5
`define TFP_CFG_FAN_OFF 0
`define TFP_CFG_INT_EN 1
`define TFP_CFG_GPI_HIGH 2
`define TFP_INT_OVER_TEMP 0
`define TFP_INT_GPI 4
`define TFP_REM_RESET 0
`define TFP_REM_OFF 1
`define TFP_ALERT_OVER_TEMP 0
`define TFP_ALERT_GPI 1
`define TFP_ALERT_PWR_LOST 2
`define TFP_ALERT_TEST 3
`define TFP_BYTE_ZERO 8'h00
`define TFP_BYTE_FULL 8'hFF
`define TFP_SMB_ADDR 7'h2E
`define TFP_BIT_LAST 4'h8
`define TFP_PIN_RESET 6'h36
`define TFP_CLK_PERIOD_NS 40
`define TFP_RRST_PULSE_NS 1000
`define TFP_RRST_CYCLES ((`TFP_RRST_PULSE_NS + `TFP_CLK_PERIOD_NS - 1) / `TFP_CLK_PERIOD_NS)
`define TFP_HTRANS_NONSEQ 2'h2
`define TFP_HTRANS_SEQ 2'h3
`endif

// File: rtl/tfp_pkg.sv
// Types shared by the thermal fan pin control block
package tfp_pkg;
    // Pins from outside the clock domain, in synchroniser order
    typedef struct packed {
        logic scl;
        logic sda;
        logic boardTestEnable;
        logic mainPowerN;
        logic auxResetN;
        logic generalInput;
    } tfp_pins_t;

    // One open-drain pin: level driven and its enable
    typedef struct packed {
        logic out;
        logic oe;
    } tfp_od_t;

    // Internal register write request
    typedef struct packed {
        logic en;
        logic [2:0] idx;
        logic [7:0] data;
    } tfp_wr_t;

    typedef enum logic [2:0] {
        SMB_IDLE, SMB_ADDR, SMB_ADDR_ACK, SMB_WDATA, SMB_WACK, SMB_RDATA, SMB_RACK
    } tfp_smb_state_t;
endpackage : tfp_pkg

// File: tb/tfp_pin_control_props.sv
// Port checker of the thermal fan pin control block
`timescale 1ns/1ps
module tfp_pin_control_props
    import tfp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic aux_reset_n,
    input wire logic mainPowerN,
    input wire logic board_test_enable,
    input wire logic overTempHit,
    input wire logic [7:0] fan_speed_analog,
    input wire logic fanSpeedOe,
    input wire logic fanOffOut,
    input wire logic overTempPrimaryOe,
    input wire logic over_temp_secondary_n,
    input wire logic overTempSecondaryOe,
    input wire logic remoteResetOut,
    input wire logic remoteResetOe,
    input wire logic remoteOff,
    input wire logic intOut,
    input wire logic intOe,
    input wire logic smbSdaOut
);
    localparam int RrstLen = 1000 / 40;
    int pulseLen_q;
    // Length of the running remote reset pulse, zero between pulses
    always_ff @(posedge sys_clk) begin
        if (reset || !remoteResetOe) pulseLen_q <= 0;
        else pulseLen_q <= pulseLen_q + 1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not OKAY");
    drive_low_a: assert property (!fanOffOut && !intOut && !remoteResetOut && !smbSdaOut
        && !over_temp_secondary_n) else $error("open drain level not low");
    second_mirror_a: assert property (overTempSecondaryOe == overTempHit)
        else $error("secondary alarm differs");
    alarm_drive_a: assert property (!board_test_enable [*4] |->
        overTempPrimaryOe == overTempHit && fanSpeedOe) else $error("primary alarm wrong");
    test_route_a: assert property (board_test_enable [*4] |->
        overTempPrimaryOe && !fanSpeedOe) else $error("test mode pins wrong");
    fan_full_a: assert property (mainPowerN [*4] ##1 (overTempHit && mainPowerN) [*2] |->
        fan_speed_analog == 8'hFF) else $error("fan not full on alarm");
    power_lost_a: assert property (!mainPowerN [*5] |->
        !remoteOff && fan_speed_analog == 8'h00) else $error("power lost not obeyed");
    off_hold_a: assert property ((mainPowerN && aux_reset_n) [*4] ##0 remoteOff |=>
        remoteOff) else $error("remote off dropped");
    pulse_len_a: assert property ($fell(remoteResetOe) |-> pulseLen_q == RrstLen)
        else $error("remote reset pulse length");
    int_default_a: assert property ($fell(reset) |-> !intOe)
        else $error("interrupt on after reset");
endmodule : tfp_pin_control_props

bind tfp_pin_control tfp_pin_control_props props (.*);

// File: tb/tfp_smb_host.sv
// SMBus host model that frames register writes and reads
`timescale 1ns/1ps
module tfp_smb_host (
    output logic scl,
    output logic sdaOe,
    input wire logic sda
);
    localparam int Q = 80; // Quarter of the 320 ns link clock
    // Clock stands high and data is released outside frames
    initial begin
        scl = 1'b1;
        sdaOe = 1'b0;
    end
    // Data changes only while the clock is low
    task automatic bit_io(input logic bv, output logic rv);
        scl = 1'b0;
        #Q sdaOe = !bv;
        #Q scl = 1'b1;
        #Q rv = sda;
        #Q;
    endtask : bit_io
    // Low phase first, so a slave still acking lets go
    task automatic start();
        scl = 1'b0;
        #Q sdaOe = 1'b0;
        #Q scl = 1'b1;
        #Q sdaOe = 1'b1;
        #Q;
    endtask : start
    task automatic stop();
        scl = 1'b0;
        #Q sdaOe = 1'b1;
        #Q scl = 1'b1;
        #Q sdaOe = 1'b0;
        #Q;
    endtask : stop
    // MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(1'b1, ack);
    endtask : xfer
    // Pointer byte then one data byte
    task automatic write_reg(input logic [6:0] a, input logic [2:0] idx, input logic [7:0] d,
        output logic [2:0] acks);
        logic [7:0] q;
        #13;
        start();
        xfer({a, 1'b0}, q, acks[2]);
        xfer({5'h00, idx}, q, acks[1]);
        xfer(d, q, acks[0]);
        stop();
    endtask : write_reg
    // Pointer write, repeated start, one byte read with no acknowledge
    task automatic read_reg(input logic [6:0] a, input logic [2:0] idx, output logic [7:0] d,
        output logic [2:0] acks);
        logic [7:0] q;
        logic nack;
        #13;
        start();
        xfer({a, 1'b0}, q, acks[2]);
        xfer({5'h00, idx}, q, acks[1]);
        start();
        xfer({a, 1'b1}, q, acks[0]);
        xfer(8'hFF, d, nack);
        stop();
    endtask : read_reg
endmodule : tfp_smb_host

// File: tb/tb_top.sv
// Self-checking bench of the thermal fan pin control block
`timescale 1ns/1ps
`include "tfp_consts.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errTotal++; \
$display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_top
    import tfp_pkg::*;
;
    logic sys_clk = 0, reset = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, seed = 3, v;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2, acks;
    logic general_input = 0, aux_reset_n = 1, mainPowerN = 1, board_test_enable = 0;
    logic overTempHit = 0, smbScl, smbSdaIn, hostSdaOe, smbSdaOut, smbSdaOe;
    logic [7:0] fan_speed_analog, b;
    logic fanSpeedOe, fanOffOut, fanOffOe, over_temp_primary_n, overTempPrimaryOe;
    logic over_temp_secondary_n, overTempSecondaryOe, remoteResetOut, remoteResetOe;
    logic remoteOff, intOut, intOe;
    int errTotal = 0, checks = 0, cycles = 0, n;
    always #20 sys_clk = ~sys_clk;
    // Pull-up on the data line, low while anyone drives it
    assign smbSdaIn = !(hostSdaOe || smbSdaOe);
    tfp_pin_control dut (.hready(hreadyout), .*);
    tfp_smb_host host (.scl(smbScl), .sdaOe(hostSdaOe), .sda(smbSdaIn));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    // NAND chain in tree order: data, clock, power, aux reset, general input
    function automatic logic tree(input logic [4:0] p);
        logic c;
        c = p[0];
        for (int i = 1; i < 5; i++) c = ~(c & p[i]);
        return c;
    endfunction : tree
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    // Ceiling well above the expected run length
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errTotal++;
            wrap_up();
        end
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask : cyc
    // One single transfer; waits on ready with no assumed latency
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= `TFP_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic wr(input logic [2:0] idx, input logic [31:0] d);
        logic [31:0] t;
        ahb(1'b1, {27'h000_0000, idx, 2'h0}, d, t);
        cyc(1);
    endtask : wr
    task automatic rd(input logic [2:0] idx, output logic [31:0] d);
        ahb(1'b0, {27'h000_0000, idx, 2'h0}, 32'h0000_0000, d);
    endtask : rd
    initial begin
        cyc(3);
        reset <= 1'b0;
        cyc(4);
        rd(`TFP_IDX_CONFIG, v);
        `CHK("config reset", 32'h0000_0000, v)
        `CHK("int after reset", 1'b0, intOe)
        ahb(1'b0, 32'h0000_0100, 32'h0000_0000, v);
        `CHK("unmapped read", 32'h0000_0000, v)
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(`TFP_IDX_FAN_DAC, {24'h00_0000, seed[7:0]});
            cyc(1);
            `CHK("fan code", seed[7:0], fan_speed_analog)
            host.write_reg(`TFP_SMB_ADDR, `TFP_IDX_FAN_DAC, ~seed[7:0], acks);
            `CHK("write acks", 3'h0, acks)
            host.read_reg(`TFP_SMB_ADDR, `TFP_IDX_FAN_DAC, b, acks);
            `CHK("read acks", 3'h0, acks)
            `CHK("serial read", ~seed[7:0], b)
            host.write_reg(7'h2F, `TFP_IDX_FAN_DAC, seed[7:0], acks);
            `CHK("foreign acks", 3'h7, acks)
            cyc(1);
            rd(`TFP_IDX_FAN_DAC, v);
            `CHK("dac kept", {24'h00_0000, ~seed[7:0]}, v)
        end
        $display("serial slave done");
        wr(`TFP_IDX_CONFIG, 32'h0000_0001);
        `CHK("fan off on", 1'b1, fanOffOe)
        wr(`TFP_IDX_CONFIG, 32'h0000_0006);
        `CHK("fan off released", 1'b0, fanOffOe)
        wr(`TFP_IDX_INT_MASK, 32'h0000_0000);
        wr(`TFP_IDX_INT_STATUS, 32'h0000_00FF);
        `CHK("int idle", 1'b0, intOe)
        general_input <= 1'b1;
        cyc(5);
        rd(`TFP_IDX_INT_STATUS, v);
        `CHK("gpi high sets", 1'b1, v[4])
        `CHK("int on", 1'b1, intOe)
        wr(`TFP_IDX_INT_MASK, 32'h0000_0010);
        `CHK("int masked", 1'b0, intOe)
        wr(`TFP_IDX_CONFIG, 32'h0000_0002);
        wr(`TFP_IDX_INT_STATUS, 32'h0000_0010);
        rd(`TFP_IDX_INT_STATUS, v);
        `CHK("high inactive", 1'b0, v[4])
        general_input <= 1'b0;
        wr(`TFP_IDX_INT_MASK, 32'h0000_0000);
        cyc(4);
        rd(`TFP_IDX_INT_STATUS, v);
        `CHK("zero active low", 1'b1, v[4])
        `CHK("int unmasked", 1'b1, intOe)
        wr(`TFP_IDX_CONFIG, 32'h0000_0000);
        `CHK("int disabled", 1'b0, intOe)
        $display("interrupt done");
        overTempHit <= 1'b1;
        cyc(3);
        `CHK("alarm oe", 1'b1, overTempPrimaryOe)
        `CHK("alarm mirror", 1'b1, overTempSecondaryOe)
        `CHK("fan full", 8'hFF, fan_speed_analog)
        overTempHit <= 1'b0;
        rd(`TFP_IDX_INT_STATUS, v);
        `CHK("alarm status", 1'b1, v[0])
        $display("over temperature done");
        wr(`TFP_IDX_REMOTE, 32'h0000_0001);
        n = 0;
        // Pulse already stands on the edge the write task returns at
        repeat (40) begin
            if (remoteResetOe === 1'b1) n++;
            @(posedge sys_clk);
        end
        `CHK("pulse cycles", 1000 / 40, n)
        host.write_reg(`TFP_SMB_ADDR, `TFP_IDX_REMOTE, 8'h02, acks);
        cyc(2);
        `CHK("remote off", 1'b1, remoteOff)
        wr(`TFP_IDX_REMOTE, 32'h0000_0000);
        rd(`TFP_IDX_REMOTE, v);
        `CHK("off held", 2'h2, v[1:0])
        mainPowerN <= 1'b0;
        cyc(5);
        `CHK("off cleared", 1'b0, remoteOff)
        `CHK("fan stopped", 8'h00, fan_speed_analog)
        mainPowerN <= 1'b1;
        rd(`TFP_IDX_REMOTE, v);
        `CHK("off bit cleared", 1'b0, v[1])
        $display("remote functions done");
        board_test_enable <= 1'b1;
        cyc(4);
        `CHK("test fan pin", 1'b0, fanSpeedOe)
        `CHK("test tree pin", 1'b1, overTempPrimaryOe)
        `CHK("tree level", tree({general_input, aux_reset_n, mainPowerN, smbScl, smbSdaIn}), over_temp_primary_n)
        board_test_enable <= 1'b0;
        cyc(4);
        `CHK("fan pin back", 1'b1, fanSpeedOe)
        wr(`TFP_IDX_CONFIG, 32'h0000_0002);
        aux_reset_n <= 1'b0;
        cyc(4);
        aux_reset_n <= 1'b1;
        cyc(4);
        rd(`TFP_IDX_CONFIG, v);
        `CHK("aux reset", 32'h0000_0000, v)
        $display("test mode and aux reset done");
        wrap_up();
    end
endmodule : tb_top
